// ### common/tsp_regs.svh
// Purpose: constants of the two-wire thermostat sensor: pointers, fields, resets
// Assumes: included by the package user files by bare name
// Notes: bus address high nibble and threshold reset values are plain defaults
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH

`define TSP_PTR_TEMP   2'h0
`define TSP_PTR_CFG    2'h1
`define TSP_PTR_LOW    2'h2
`define TSP_PTR_HIGH   2'h3

`define TSP_CFG_SD     0
`define TSP_CFG_TM     1
`define TSP_CFG_POL    2
`define TSP_CFG_FLO    3
`define TSP_CFG_FHI    4
`define TSP_CFG_RLO    5
`define TSP_CFG_RHI    6
`define TSP_CFG_RST    8'h00
`define TSP_CFG_WMASK  8'h7F

`define TSP_TEMP_RST   16'h0000
`define TSP_LOW_RST    16'h4B00
`define TSP_HIGH_RST   16'h5000
`define TSP_ADDR_HI    4'h9

`define TSP_FAULT_N0   3'h1
`define TSP_FAULT_N1   3'h2
`define TSP_FAULT_N2   3'h4
`define TSP_FAULT_N3   3'h6

`endif

// ### common/tsp_pkg.sv
// Purpose: types of the thermostat sensor
// Assumes: nothing
// Notes: bus engine states
`default_nettype none
package tsp_pkg;
    typedef logic [15:0] tsp_word_t;
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_ADDR  = 3'h1,
        S_ACKP  = 3'h2,
        S_ACK   = 3'h3,
        S_WR    = 3'h4,
        S_RD    = 3'h5,
        S_RACKP = 3'h6,
        S_RACK  = 3'h7
    } tsp_state_t;
endpackage : tsp_pkg
`default_nettype wire

// ### common/tsp_if.sv
// Purpose: link between the bus front end and the thermostat core
// Assumes: one clock
// Notes: ctl drives the settings, thr returns the pin level
`timescale 1ns/1ps
`default_nettype none
interface tsp_if;
    tsp_pkg::tsp_word_t temp;
    tsp_pkg::tsp_word_t hi;
    tsp_pkg::tsp_word_t lo;
    logic               temp_stb;
    logic               output_polarity_bit;
    logic               tm;
    logic [1:0]         fq;
    logic               rd_clr;
    logic               os_pin;
    modport ctl (output temp, hi, lo, temp_stb, output_polarity_bit, tm, fq, rd_clr, input os_pin);
    modport thr (input temp, hi, lo, temp_stb, output_polarity_bit, tm, fq, rd_clr, output os_pin);
endinterface : tsp_if
`default_nettype wire

// ### rtl/tsp_thermo.sv
// Purpose: thermostat core: fault counting, comparator and interrupt modes, pin polarity
// Assumes: temp_stb marks a fresh conversion, rd_clr a bus read of the device
// Notes: one counter serves whichever limit is being watched
`timescale 1ns/1ps
`default_nettype none
`include "tsp_regs.svh"
module tsp_thermo (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // core link
    tsp_if.thr       lnk
);
    import tsp_pkg::*;

    logic [2:0] cnt_r;
    logic       cmp_act_r;
    logic       ev_r;
    logic       dir_r;
    logic       os_r;
    logic       over;
    logic       under;
    logic       seek_high;
    logic       beyond;
    logic       fire;
    logic       act;

    function automatic logic [2:0] fault_need(input logic [1:0] f);
        logic [2:0] n;
        n = `TSP_FAULT_N0;
        unique case (f)
            2'h0: n = `TSP_FAULT_N0;
            2'h1: n = `TSP_FAULT_N1;
            2'h2: n = `TSP_FAULT_N2;
            2'h3: n = `TSP_FAULT_N3;
        endcase
        return n;
    endfunction : fault_need

    // readings and limits are two's complement
    assign over      = $signed(lnk.temp) > $signed(lnk.hi);
    assign under     = $signed(lnk.temp) < $signed(lnk.lo);
    assign seek_high = lnk.tm ? !dir_r : !cmp_act_r;
    assign beyond    = seek_high ? over : under;
    assign fire      = lnk.temp_stb && beyond && ((cnt_r + 3'h1) >= fault_need(lnk.fq));
    assign act       = lnk.tm ? ev_r : cmp_act_r;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            cnt_r <= 3'h0;
        else if (lnk.temp_stb)
            cnt_r <= (!beyond || fire) ? 3'h0 : cnt_r + 3'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            cmp_act_r <= 1'b0;
        else if (fire && !lnk.tm)
            cmp_act_r <= seek_high;
    end

    // a new event beats a read clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            ev_r  <= 1'b0;
            dir_r <= 1'b0;
        end
        else if (fire && lnk.tm)
        begin
            ev_r  <= 1'b1;
            dir_r <= !dir_r;
        end
        else if (lnk.rd_clr)
            ev_r <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            os_r <= 1'b1;
        else
            os_r <= lnk.output_polarity_bit ? act : !act;
    end

    assign lnk.os_pin = os_r;

    a_pol_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (lnk.output_polarity_bit && act) |=> lnk.os_pin) else $error("active output not high");
    a_pol_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!lnk.output_polarity_bit && act) |=> !lnk.os_pin) else $error("active output not low");
    a_over_trip: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!lnk.tm && !cmp_act_r && lnk.temp_stb && over && lnk.fq == 2'h0) |=> cmp_act_r)
        else $error("single over reading did not trip");
    a_hyst_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (cmp_act_r && !(lnk.temp_stb && under)) |=> cmp_act_r)
        else $error("released above low limit");
    a_fault_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!lnk.tm && !cmp_act_r && cnt_r == 3'h0 && lnk.fq == 2'h3) |=> !cmp_act_r)
        else $error("tripped before six conversions");
    a_int_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ev_r && lnk.rd_clr && !fire) |=> !ev_r) else $error("read did not clear event");
endmodule : tsp_thermo
`default_nettype wire

// ### rtl/tsp_top.sv
// Purpose: two-wire slave with pointer-selected registers and a thermostat output
// Assumes: scl and sda already synchronous to sys_clk and glitch free
// Notes: sda is open drain, sda_oe high pulls the wire low
`timescale 1ns/1ps
`default_nettype none
`include "tsp_regs.svh"
module tsp_top (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    // two-wire bus
    input  wire logic               scl_i,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe,
    // address straps
    input  wire logic               slave_addr_bit2,
    input  wire logic               slave_addr_bit1,
    input  wire logic               slave_addr_bit0,
    // conversion front end
    input  wire tsp_pkg::tsp_word_t temp_data,
    input  wire logic               temp_valid,
    output logic                    conv_run,
    output logic [1:0]              conv_res,
    // thermostat
    output logic                    os_o
);
    import tsp_pkg::*;

    tsp_if link ();

    tsp_thermo u_thermo (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .lnk     (link.thr)
    );

    logic       scl_q_r;
    logic       sda_q_r;
    tsp_state_t state_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shreg_r;
    logic       rw_r;
    logic       drv_r;
    logic [1:0] widx_r;
    logic       ridx_r;
    logic [7:0] tx_r;
    logic [7:0] snap_r;
    logic [1:0] ptr_r;
    logic [7:0] msb_r;
    logic [7:0] cfg_r;
    tsp_word_t  low_r;
    tsp_word_t  high_r;
    tsp_word_t  temp_r;
    logic       stb_r;
    logic       rd_clr_r;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       byte_end;
    logic [7:0] in_byte;
    logic [6:0] my_addr;
    logic       addr_hit;
    logic       wr_byte;
    logic       data_wr;
    logic       rd_load;
    logic       load_idx;

    function automatic logic [7:0] rd_byte(input logic [1:0] p, input logic idx,
                                           input tsp_word_t t, input logic [7:0] s,
                                           input logic [7:0] c, input tsp_word_t lo,
                                           input tsp_word_t hi);
        logic [7:0] b;
        b = 8'h00;
        unique case (p)
            `TSP_PTR_TEMP: b = idx ? s : t[15:8];
            `TSP_PTR_CFG:  b = c;
            `TSP_PTR_LOW:  b = idx ? lo[7:0] : lo[15:8];
            `TSP_PTR_HIGH: b = idx ? hi[7:0] : hi[15:8];
        endcase
        return b;
    endfunction : rd_byte

    assign scl_rise = scl_i && !scl_q_r;
    assign scl_fall = !scl_i && scl_q_r;
    assign start_c  = scl_i && scl_q_r && sda_q_r && !sda_i;
    assign stop_c   = scl_i && scl_q_r && !sda_q_r && sda_i;
    assign byte_end = scl_rise && (bit_cnt_r == 3'h7);
    assign in_byte  = {shreg_r[6:0], sda_i};
    assign my_addr  = {`TSP_ADDR_HI, slave_addr_bit2, slave_addr_bit1, slave_addr_bit0};
    assign addr_hit = (state_r == S_ADDR) && byte_end && (shreg_r[6:0] == my_addr);
    assign wr_byte  = (state_r == S_WR) && byte_end;
    assign data_wr  = wr_byte && (widx_r != 2'h0);
    assign rd_load  = (addr_hit && sda_i) || ((state_r == S_RACK) && scl_rise && !sda_i);
    assign load_idx = (state_r == S_ADDR) ? 1'b0 : ridx_r;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
        end
    end

    // start and stop win over any bit in flight, so a stuck transfer always recovers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_r   <= S_IDLE;
            bit_cnt_r <= 3'h0;
            shreg_r   <= 8'h00;
            rw_r      <= 1'b0;
            drv_r     <= 1'b0;
            widx_r    <= 2'h0;
        end
        else if (start_c)
        begin
            state_r   <= S_ADDR;
            bit_cnt_r <= 3'h0;
            drv_r     <= 1'b0;
            widx_r    <= 2'h0;
        end
        else if (stop_c)
        begin
            state_r <= S_IDLE;
            drv_r   <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                S_IDLE:
                begin
                end
                S_ADDR:
                    if (scl_rise)
                    begin
                        shreg_r   <= in_byte;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7)
                        begin
                            rw_r    <= sda_i;
                            state_r <= addr_hit ? S_ACKP : S_IDLE;
                        end
                    end
                S_WR:
                    if (scl_rise)
                    begin
                        shreg_r   <= in_byte;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7)
                        begin
                            state_r <= S_ACKP;
                            if (widx_r != 2'h3)
                                widx_r <= widx_r + 2'h1;
                        end
                    end
                S_ACKP:
                    if (scl_fall)
                    begin
                        drv_r   <= 1'b1;
                        state_r <= S_ACK;
                    end
                S_ACK:
                    if (scl_fall)
                    begin
                        bit_cnt_r <= 3'h0;
                        state_r   <= rw_r ? S_RD : S_WR;
                        drv_r     <= rw_r && !tx_r[7];
                    end
                S_RD:
                begin
                    if (scl_fall)
                        drv_r <= !tx_r[3'h7 - bit_cnt_r];
                    if (scl_rise)
                    begin
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        if (bit_cnt_r == 3'h7)
                            state_r <= S_RACKP;
                    end
                end
                S_RACKP:
                    if (scl_fall)
                    begin
                        drv_r   <= 1'b0;
                        state_r <= S_RACK;
                    end
                S_RACK:
                    if (scl_rise)
                    begin
                        bit_cnt_r <= 3'h0;
                        state_r   <= sda_i ? S_IDLE : S_RD;
                    end
            endcase
        end
    end

    // the low temperature byte is frozen when the high byte goes out, so a word never tears
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            tx_r   <= 8'h00;
            ridx_r <= 1'b0;
            snap_r <= 8'h00;
        end
        else if (rd_load)
        begin
            tx_r   <= rd_byte(ptr_r, load_idx, temp_r, snap_r, cfg_r, low_r, high_r);
            ridx_r <= !load_idx;
            if (!load_idx)
                snap_r <= temp_r[7:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ptr_r <= `TSP_PTR_TEMP;
        else if (wr_byte && widx_r == 2'h0)
            ptr_r <= in_byte[1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            msb_r <= 8'h00;
            cfg_r <= `TSP_CFG_RST;
        end
        else if (data_wr && widx_r == 2'h1)
        begin
            msb_r <= in_byte;
            if (ptr_r == `TSP_PTR_CFG)
                cfg_r <= in_byte & `TSP_CFG_WMASK;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            low_r  <= `TSP_LOW_RST;
            high_r <= `TSP_HIGH_RST;
        end
        else if (data_wr && widx_r == 2'h2)
        begin
            if (ptr_r == `TSP_PTR_LOW)
                low_r <= {msb_r, in_byte};
            if (ptr_r == `TSP_PTR_HIGH)
                high_r <= {msb_r, in_byte};
        end
    end

    // in standby the last reading is kept and no comparison runs
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            temp_r <= `TSP_TEMP_RST;
            stb_r  <= 1'b0;
        end
        else
        begin
            stb_r <= temp_valid && !cfg_r[`TSP_CFG_SD];
            if (temp_valid && !cfg_r[`TSP_CFG_SD])
                temp_r <= temp_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            rd_clr_r <= 1'b0;
        else
            rd_clr_r <= addr_hit && sda_i;
    end

    assign link.temp     = temp_r;
    assign link.temp_stb = stb_r;
    assign link.hi       = high_r;
    assign link.lo       = low_r;
    assign link.output_polarity_bit      = cfg_r[`TSP_CFG_POL];
    assign link.tm       = cfg_r[`TSP_CFG_TM];
    assign link.fq       = cfg_r[`TSP_CFG_FHI:`TSP_CFG_FLO];
    assign link.rd_clr   = rd_clr_r;

    assign sda_o    = 1'b0;
    assign sda_oe   = drv_r;
    assign conv_run = !cfg_r[`TSP_CFG_SD];
    assign conv_res = cfg_r[`TSP_CFG_RHI:`TSP_CFG_RLO];
    assign os_o     = link.os_pin;

    a_stop_idles: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (stop_c && !start_c) |=> (state_r == S_IDLE) && !sda_oe) else $error("stop not idled");
    a_addr_reject: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!start_c && !stop_c && state_r == S_ADDR && byte_end && shreg_r[6:0] != my_addr)
        |=> (state_r == S_IDLE) ##1 !sda_oe) else $error("foreign address taken");
    a_ptr_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (wr_byte && widx_r == 2'h0) |=> ptr_r == $past({shreg_r[0], sda_i}))
        else $error("pointer byte not taken");
    a_high_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (data_wr && widx_r == 2'h2 && ptr_r == `TSP_PTR_HIGH) |=> high_r == {$past(msb_r), $past(in_byte)})
        else $error("high limit not loaded");
    a_reset_default: assert property (@(posedge sys_clk)
        sys_rst |=> (ptr_r == `TSP_PTR_TEMP) && (cfg_r == `TSP_CFG_RST))
        else $error("reset defaults wrong");
    a_shutdown_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cfg_r[`TSP_CFG_SD] |=> $stable(temp_r) && !link.temp_stb) else $error("converted in standby");
endmodule : tsp_top
`default_nettype wire

// ### bench/tsp_host.sv
// Purpose: two-wire bus controller model facing the sensor's serial port
// Assumes: in each bit scl is high four sys_clk cycles and low five, sda is resolved outside with a pull-up
// Notes: res_stb marks each ack slot sampled (1 ack, 0 nack) or byte read, res_val carries it for one cycle
`timescale 1ns/1ps
`default_nettype none
module tsp_host (
    // clock
    input  wire logic       sys_clk,
    // two-wire bus
    output var  logic       scl,
    output var  logic       sda_drv,
    input  wire logic       sda,
    // results
    output var  logic       res_stb,
    output var  logic [7:0] res_val
);
    initial
    begin
        scl     = 1'b1;
        sda_drv = 1'b1;
        res_stb = 1'b0;
        res_val = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    task automatic note(input logic [7:0] v);
        res_val = v;
        res_stb = 1'b1;
        tick(1);
        res_stb = 1'b0;
    endtask : note

    // sda only moves while scl is low, so no false start or stop is seen
    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        tick(4);
        scl = 1'b1;
        tick(2);
        s = sda;
        tick(2);
        scl = 1'b0;
        tick(1);
    endtask : bit_io

    // also serves as a repeated start from scl low
    task automatic bus_start();
        sda_drv = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b0;
        tick(1);
    endtask : bus_start

    task automatic bus_stop();
        sda_drv = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_drv = 1'b1;
        tick(4);
    endtask : bus_stop

    // msb first, then the ack slot with sda released
    task automatic send_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        note({7'h00, !s});
    endtask : send_byte

    task automatic recv_byte(input logic last);
        logic       s;
        logic [7:0] v;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            v[i] = s;
        end
        bit_io(last, s);
        note(v);
    endtask : recv_byte
endmodule : tsp_host
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: self-checking bench of the two-wire thermostat sensor
// Assumes: tsp_host plays the bus controller, the bench drives the conversion side
// Notes: expected bus results queue up and a monitor compares them as they appear
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tsp_pkg::*;
    logic       sys_clk      = 1'b0;
    logic       sys_rst      = 1'b1;
    logic [2:0] addr         = 3'h0;
    tsp_word_t  temp_data    = 16'h0000;
    logic       temp_valid   = 1'b0;
    logic       scl;
    logic       sda_drv;
    logic       sda;
    logic       sda_o;
    logic       sda_oe;
    logic       conv_run;
    logic [1:0] conv_res;
    logic       os_o;
    logic       res_stb;
    logic [7:0] res_val;
    logic [7:0] exp_q[$];
    int         n_mismatch   = 0;
    int         total_checks = 0;
    int         cyc          = 0;

    always #50 sys_clk = ~sys_clk;
    // open drain with pull-up: the wire is low if either side pulls
    assign sda = sda_drv & (sda_oe ? sda_o : 1'b1);

    tsp_host host (.sys_clk(sys_clk), .scl(scl), .sda_drv(sda_drv), .sda(sda),
                   .res_stb(res_stb), .res_val(res_val));
    tsp_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda),
                 .sda_o(sda_o), .sda_oe(sda_oe), .slave_addr_bit2(addr[2]),
                 .slave_addr_bit1(addr[1]), .slave_addr_bit0(addr[0]),
                 .temp_data(temp_data), .temp_valid(temp_valid), .conv_run(conv_run),
                 .conv_res(conv_res), .os_o(os_o));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    always @(posedge sys_clk)
    begin
        cyc++;
        if (res_stb === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("bus extra", {8'h00, res_val}, 16'hFFFF);
            else
                check("bus", {8'h00, res_val}, {8'h00, exp_q.pop_front()});
        end
        if (cyc == 60000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    // data bytes go msb first from d; a one-byte register takes d[15:8]
    task automatic wr_reg(input logic [1:0] p, input logic [15:0] d, input int nb);
        host.bus_start();
        exp_q.push_back(8'h01);
        host.send_byte({4'h9, addr, 1'b0});
        exp_q.push_back(8'h01);
        host.send_byte({6'h00, p});
        for (int i = 0; i < nb; i++)
        begin
            exp_q.push_back(8'h01);
            host.send_byte(i == 0 ? d[15:8] : d[7:0]);
        end
        host.bus_stop();
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] d, input int nb);
        host.bus_start();
        exp_q.push_back(8'h01);
        host.send_byte({4'h9, addr, 1'b1});
        for (int i = 0; i < nb; i++)
        begin
            exp_q.push_back(i == 0 ? d[15:8] : d[7:0]);
            host.recv_byte(i == nb - 1);
        end
        host.bus_stop();
    endtask : rd_reg

    task automatic conv(input logic [15:0] t, input logic act, input logic output_polarity_bit);
        temp_data  = t;
        temp_valid = 1'b1;
        @(negedge sys_clk);
        temp_valid = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("os_o", {15'h0000, os_o}, {15'h0000, output_polarity_bit ? act : !act});
    endtask : conv

    initial
    begin
        logic [15:0] d;
        logic        output_polarity_bit;
        int          nf;
        void'($urandom(99131));
        repeat (16) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        check("conv_run", {15'h0000, conv_run}, 16'h0001);
        check("conv_res", {14'h0000, conv_res}, 16'h0000);
        check("os_o", {15'h0000, os_o}, 16'h0001);
        check("sda", {14'h0000, sda_o, sda_oe}, 16'h0000);
        rd_reg(16'h0000, 2);
        for (int p = 1; p < 4; p++)
        begin
            wr_reg(p[1:0], 16'h0000, 0);
            rd_reg(p == 1 ? 16'h0000 : p == 2 ? 16'h4B00 : 16'h5000, p == 1 ? 1 : 2);
        end
        $display("test reset done");
        for (int a = 0; a < 8; a++)
        begin
            addr = a[2:0];
            d = 16'($urandom());
            wr_reg({1'b1, a[0]}, d, 2);
            rd_reg(d, 2);
            host.bus_start();
            exp_q.push_back(8'h00);
            host.send_byte({4'h9, ~addr, 1'b0});
            host.bus_stop();
        end
        $display("test address done");
        addr = 3'($urandom_range(7, 0));
        wr_reg(2'h1, 16'hFF00, 1);
        rd_reg(16'h7F00, 1);
        check("conv_run", {15'h0000, conv_run}, 16'h0000);
        check("conv_res", {14'h0000, conv_res}, 16'h0003);
        conv(16'h7000, 1'b0, 1'b1);
        wr_reg(2'h0, 16'hFFFF, 2);
        rd_reg(16'h0000, 2);
        wr_reg(2'h3, 16'h1400, 2);
        wr_reg(2'h2, 16'h0A00, 2);
        $display("test config done");
        for (int f = 0; f < 4; f++)
        begin
            output_polarity_bit = 1'($urandom_range(1, 0));
            nf  = (f == 3) ? 6 : (1 << f);
            wr_reg(2'h1, {3'b000, f[1:0], output_polarity_bit, 2'b00, 8'h00}, 1);
            conv(16'h1400, 1'b0, output_polarity_bit);
            for (int i = 0; i < nf; i++)
                conv(16'h1401 + 16'($urandom_range(255, 0)), i == nf - 1, output_polarity_bit);
            conv(16'h0A00, 1'b1, output_polarity_bit);
            for (int i = 0; i < nf; i++)
                conv(16'h09FF - 16'($urandom_range(255, 0)), i != nf - 1, output_polarity_bit);
        end
        wr_reg(2'h0, 16'h0000, 0);
        rd_reg(temp_data, 2);
        $display("test comparator done");
        wr_reg(2'h1, 16'h0600, 1);
        conv(16'h2000, 1'b1, 1'b1);
        rd_reg(16'h0600, 1);
        check("os_o", {15'h0000, os_o}, 16'h0000);
        conv(16'h2000, 1'b0, 1'b1);
        conv(16'h0000, 1'b1, 1'b1);
        rd_reg(16'h0600, 1);
        check("os_o", {15'h0000, os_o}, 16'h0000);
        $display("test interrupt done");
        repeat (20) @(negedge sys_clk);
        check("queue", 16'(exp_q.size()), 16'h0000);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
